// ---- core/rtc_pkg.sv ----
/*
  Constants, register layouts and shared types of the real-time clock
  time, calendar and alarm register block.
  Assumes one 20 MHz clock and an Avalon-MM slave port with waitrequest.
*/
// What this block does
// R1: Seconds and minutes accept BCD 00 to 59 only.
// R2: Each BCD field keeps units in its low nibble, tens above.
// R3: Hour accepts 01 to 12 in twelve-hour mode, 00 to 23 otherwise.
// R4: Time bit 22 marks morning (0) or afternoon (1) in twelve-hour mode.
// R5: Century accepts only BCD 20; anything else is rejected.
// R6: Year accepts two BCD digits, 00 to 99.
// R7: Month accepts BCD 01 to 12.
// R8: Day of week accepts 1 to 7.
// R9: Day of week advances on its own; its meaning never affects the date.
// R10: Day of month accepts BCD 01 to 31.
// R11: Time alarm enables at bits 23, 15, 7 gate hour, minute, second compare.
// R12: Calendar alarm enables at bits 31 and 23 gate date and month compare.
// R13: Alarm flag, status bit 1, sets when an alarm match occurs.
// R14: Software changes an alarm field by disable, write, then re-enable.
// R15: Status bit 0 sets on the first second tick after a time or calendar update request, sticky.
// R16: Second flag, status bit 2, sets every second and stays until cleared.
// R17: Time-event flag, bit 3, sets on the selected time event, sticky.
// R18: Calendar-event flag, bit 4, sets on the selected calendar event, sticky.
// R19: Writing one to a flag-clear bit clears that flag; zero does nothing.
// R20: Time-event select: 0 minute, 1 hour, 2 midnight, 3 noon.
// R21: Calendar-event select: 0 week, 1 month, 2 year.
// R22: An invalid write leaves the register unchanged and sets its error flag.
// R23: Alarm matches only when all enabled fields equal the counters at once.
package rtc_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SECOND_NS = 1_000_000_000;
  localparam int unsigned SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_TIME = 8'h08;
  localparam logic [7:0] OFS_CAL = 8'h0C;
  localparam logic [7:0] OFS_TALR = 8'h10;
  localparam logic [7:0] OFS_CALR = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_CLR = 8'h1C;
  localparam logic [7:0] OFS_VALID = 8'h2C;

  // ==========================================================
  // Bit positions
  localparam int ST_ACK = 0;
  localparam int ST_ALARM = 1;
  localparam int ST_SEC = 2;
  localparam int ST_TIME_EVENT_FLAG = 3;
  localparam int ST_CALENDAR_EVENT_FLAG = 4;
  localparam int NV_TIME = 0;
  localparam int NV_CAL = 1;
  localparam int NV_TALR = 2;
  localparam int NV_CALR = 3;
  localparam int CTRL_UPD_TIME = 0;
  localparam int CTRL_UPD_CAL = 1;
  localparam int CTRL_TEVSEL_LSB = 8;
  localparam int CTRL_CEVSEL_LSB = 16;
  localparam int MODE_H12 = 0;

  // ==========================================================
  // BCD limits
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] MINSEC_MAX = 8'h59;
  localparam logic [7:0] HOUR24_MAX = 8'h23;
  localparam logic [7:0] HOUR12_MAX = 8'h12;
  localparam logic [7:0] HOUR_PRE_NOON = 8'h11;
  localparam logic [7:0] HUNDREDS_OF_YEARS_FIELD_ONLY = 8'h20;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] DAY_MAX = 8'h07;
  localparam logic [7:0] DATE_MAX = 8'h31;

  // ==========================================================
  // Register layouts
  typedef struct packed {
    logic [7:0] unused;
    logic hour_alarm_enable;
    logic half_day_flag;
    logic [5:0] hour;
    logic minute_alarm_enable;
    logic [6:0] min;
    logic second_alarm_enable;
    logic [6:0] sec;
  } tod_word_type;

  typedef struct packed {
    logic [1:0] unused;
    logic [5:0] date;
    logic [2:0] day;
    logic [4:0] month;
    logic [7:0] year;
    logic pad;
    logic [6:0] hundreds_of_years_field;
  } cal_word_type;

  typedef struct packed {
    logic day_of_month_alarm_enable;
    logic pad_hi;
    logic [5:0] date;
    logic month_alarm_enable;
    logic [1:0] pad_mid;
    logic [4:0] month;
    logic [15:0] unused;
  } calalr_word_type;

  typedef enum logic [1:0] {
    TEV_MINUTE = 2'h0, TEV_HOUR = 2'h1, TEV_MIDNIGHT = 2'h2, TEV_NOON = 2'h3
  } time_event_select_type;

  typedef enum logic [1:0] {
    CEV_WEEK = 2'h0, CEV_MONTH = 2'h1, CEV_YEAR = 2'h2
  } calendar_event_select_type;

  // ==========================================================
  // Reset values
  localparam tod_word_type TIME_RST = 32'h0000_0000;
  localparam cal_word_type CAL_RST = 32'h0121_0720;
  localparam tod_word_type TALR_RST = 32'h0000_0000;
  localparam calalr_word_type CALR_RST = 32'h0101_0000;

endpackage : rtc_pkg

// ---- core/rtc_time_calendar_alarm_regs.sv ----
/*
  Time, calendar and alarm registers of the real-time clock with sticky
  event flags, reached over an Avalon-MM slave with waitrequest.
  Assumes a single 20 MHz clock and an asynchronous active-low reset.
*/
// The Avalon-MM register port and the register addresses were left to the implementer.
module rtc_time_calendar_alarm_regs #(
  parameter int unsigned TICK_CYCLES = rtc_pkg::SEC_CYCLES
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o
);

  // ==========================================================
  // Helpers
  function automatic logic bcd_in(input logic [7:0] v, input logic [7:0] lo,
                                  input logic [7:0] hi);
    return (v[3:0] <= 4'h9) && (v >= lo) && (v <= hi);
  endfunction

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01; // see R2
  endfunction

  function automatic logic [4:0] bcd2bin(input logic [5:0] v);
    return 5'({v[5:4], 3'b000}) + 5'({v[5:4], 1'b0}) + 5'(v[3:0]);
  endfunction

  function automatic logic [5:0] bin2bcd(input logic [4:0] b);
    logic [4:0] r;
    r = (b >= 5'h14) ? b - 5'h14 : (b >= 5'h0A) ? b - 5'h0A : b;
    return {(b >= 5'h14) ? 2'h2 : (b >= 5'h0A) ? 2'h1 : 2'h0, r[3:0]};
  endfunction

  function automatic logic [5:0] to24(input logic [5:0] h, input logic pm);
    if (h == 6'(rtc_pkg::HOUR12_MAX)) begin
      return pm ? h : 6'(rtc_pkg::BCD_ZERO);
    end
    return pm ? bin2bcd(bcd2bin(h) + 5'h0C) : h;
  endfunction

  function automatic logic [6:0] to12(input logic [5:0] h);
    logic [4:0] b;
    b = bcd2bin(h);
    if (b == 5'h00) begin
      return {1'b0, 6'(rtc_pkg::HOUR12_MAX)};
    end
    if (b >= 5'h0C) begin
      return {1'b1, (b == 5'h0C) ? h : bin2bcd(b - 5'h0C)};
    end
    return {1'b0, h};
  endfunction

  function automatic logic [5:0] month_days(input logic [7:0] y, input logic [4:0] m);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      5'h02: month_days = leap ? 6'h29 : 6'h28;
      5'h04, 5'h06, 5'h09, 5'h11: month_days = 6'h30;
      default: month_days = 6'(rtc_pkg::DATE_MAX);
    endcase
  endfunction

  // ==========================================================
  // State
  logic served_r;
  logic [31:0] cnt_r;
  logic upd_time_r, upd_cal_r, hour12_r, ack_done_r, adv_d_r;
  rtc_pkg::time_event_select_type tev_sel_r;
  rtc_pkg::calendar_event_select_type cev_sel_r;
  logic [6:0] sec_r, min_r, hundreds_of_years_field_r;
  logic [5:0] hour_r, date_r;
  logic [7:0] year_r;
  logic [4:0] month_r;
  logic [2:0] day_r;
  rtc_pkg::tod_word_type talr_r;
  rtc_pkg::calalr_word_type calr_r;
  logic [4:0] status_r;
  logic [3:0] nv_r;

  // ==========================================================
  // Bus decode; one wait state, write lands when waitrequest is low
  logic [31:0] rd_word, be_mask, wdata;
  wire logic bus_req = read_i | write_i;
  wire logic wr_go = write_i & served_r;
  wire logic wr_ctrl = wr_go && (address_i == rtc_pkg::OFS_CTRL);
  wire logic wr_mode = wr_go && (address_i == rtc_pkg::OFS_MODE);
  wire logic wr_time = wr_go && (address_i == rtc_pkg::OFS_TIME);
  wire logic wr_cal = wr_go && (address_i == rtc_pkg::OFS_CAL);
  wire logic wr_talr = wr_go && (address_i == rtc_pkg::OFS_TALR);
  wire logic wr_calr = wr_go && (address_i == rtc_pkg::OFS_CALR);
  wire logic wr_clr = wr_go && (address_i == rtc_pkg::OFS_CLR);
  assign waitrequest_o = bus_req & ~served_r;
  assign be_mask = {{8{byteenable_i[3]}}, {8{byteenable_i[2]}},
                    {8{byteenable_i[1]}}, {8{byteenable_i[0]}}};
  // Partial writes merge with the current contents
  assign wdata = (writedata_i & be_mask) | (rd_word & ~be_mask);

  // ==========================================================
  // Entry checks
  rtc_pkg::tod_word_type tw, aw;
  rtc_pkg::cal_word_type cw;
  rtc_pkg::calalr_word_type caw;
  assign tw = wdata;
  assign aw = wdata;
  assign cw = wdata;
  assign caw = wdata;

  wire logic time_ok = bcd_in(8'(tw.sec), rtc_pkg::BCD_ZERO, rtc_pkg::MINSEC_MAX) // see R1
    && bcd_in(8'(tw.min), rtc_pkg::BCD_ZERO, rtc_pkg::MINSEC_MAX)
    && (hour12_r ? bcd_in(8'(tw.hour), rtc_pkg::BCD_ONE, rtc_pkg::HOUR12_MAX) // see R3
                 : bcd_in(8'(tw.hour), rtc_pkg::BCD_ZERO, rtc_pkg::HOUR24_MAX)
                   && !tw.half_day_flag);
  wire logic talr_ok = bcd_in(8'(aw.sec), rtc_pkg::BCD_ZERO, rtc_pkg::MINSEC_MAX)
    && bcd_in(8'(aw.min), rtc_pkg::BCD_ZERO, rtc_pkg::MINSEC_MAX)
    && (hour12_r ? bcd_in(8'(aw.hour), rtc_pkg::BCD_ONE, rtc_pkg::HOUR12_MAX)
                 : bcd_in(8'(aw.hour), rtc_pkg::BCD_ZERO, rtc_pkg::HOUR24_MAX)
                   && !aw.half_day_flag);
  wire logic cal_ok = (8'(cw.hundreds_of_years_field) == rtc_pkg::HUNDREDS_OF_YEARS_FIELD_ONLY) // see R5
    && bcd_in(cw.year, rtc_pkg::BCD_ZERO, rtc_pkg::YEAR_MAX) // see R6
    && bcd_in(8'(cw.month), rtc_pkg::BCD_ONE, rtc_pkg::MONTH_MAX) // see R7
    && bcd_in(8'(cw.day), rtc_pkg::BCD_ONE, rtc_pkg::DAY_MAX) // see R8
    && bcd_in(8'(cw.date), rtc_pkg::BCD_ONE, rtc_pkg::DATE_MAX) // see R10
    && (cw.date <= month_days(cw.year, cw.month));
  wire logic calr_ok = bcd_in(8'(caw.month), rtc_pkg::BCD_ONE, rtc_pkg::MONTH_MAX)
    && bcd_in(8'(caw.date), rtc_pkg::BCD_ONE, rtc_pkg::DATE_MAX);
  // Time and calendar only load while their update request stands
  wire logic time_load = wr_time & time_ok & upd_time_r; // see R22
  wire logic cal_load = wr_cal & cal_ok & upd_cal_r; // see R22

  // ==========================================================
  // Counting chain
  wire logic tick = (cnt_r == 32'(TICK_CYCLES - 1));
  wire logic time_run = ~upd_time_r;
  // Stopping time also stops the calendar, which sits downstream
  wire logic cal_run = ~upd_time_r & ~upd_cal_r;
  wire logic adv = tick & time_run;
  wire logic sec_wrap = (8'(sec_r) == rtc_pkg::MINSEC_MAX);
  wire logic min_step = adv & sec_wrap;
  wire logic hour_step = min_step & (8'(min_r) == rtc_pkg::MINSEC_MAX);
  wire logic midnight_step = hour_step & (8'(hour_r) == rtc_pkg::HOUR24_MAX);
  wire logic noon_step = hour_step & (8'(hour_r) == rtc_pkg::HOUR_PRE_NOON);
  wire logic day_step = midnight_step & cal_run;
  wire logic month_step = day_step & (date_r == month_days(year_r, month_r));
  wire logic year_step = month_step & (8'(month_r) == rtc_pkg::MONTH_MAX);

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= 32'h0000_0000;
    end else begin
      cnt_r <= tick ? 32'h0000_0000 : cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sec_r <= rtc_pkg::TIME_RST.sec;
      min_r <= rtc_pkg::TIME_RST.min;
      hour_r <= rtc_pkg::TIME_RST.hour;
    end else if (time_load) begin
      sec_r <= tw.sec;
      min_r <= tw.min;
      hour_r <= hour12_r ? to24(tw.hour, tw.half_day_flag) : tw.hour; // see R4
    end else begin
      if (adv) begin
        sec_r <= sec_wrap ? 7'h00 : 7'(bcd_inc(8'(sec_r)));
      end
      if (min_step) begin
        min_r <= (hour_step) ? 7'h00 : 7'(bcd_inc(8'(min_r)));
      end
      if (hour_step) begin
        hour_r <= midnight_step ? 6'h00 : 6'(bcd_inc(8'(hour_r)));
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hundreds_of_years_field_r <= rtc_pkg::CAL_RST.hundreds_of_years_field;
      year_r <= rtc_pkg::CAL_RST.year;
      month_r <= rtc_pkg::CAL_RST.month;
      day_r <= rtc_pkg::CAL_RST.day;
      date_r <= rtc_pkg::CAL_RST.date;
    end else if (cal_load) begin
      hundreds_of_years_field_r <= cw.hundreds_of_years_field;
      year_r <= cw.year;
      month_r <= cw.month;
      day_r <= cw.day;
      date_r <= cw.date;
    end else if (day_step) begin
      // Weekday wraps on its own count, blind to the date
      day_r <= (8'(day_r) == rtc_pkg::DAY_MAX) ? 3'h1 : day_r + 3'h1; // see R9
      date_r <= month_step ? 6'h01 : 6'(bcd_inc(8'(date_r)));
      if (month_step) begin
        month_r <= year_step ? 5'h01 : 5'(bcd_inc(8'(month_r)));
      end
      if (year_step) begin
        year_r <= (year_r == rtc_pkg::YEAR_MAX) ? 8'h00 : bcd_inc(year_r);
      end
    end
  end

  // ==========================================================
  // Control, mode, alarms, validity
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      upd_time_r <= 1'b0;
      upd_cal_r <= 1'b0;
      tev_sel_r <= rtc_pkg::TEV_MINUTE;
      cev_sel_r <= rtc_pkg::CEV_WEEK;
      hour12_r <= 1'b0;
      talr_r <= rtc_pkg::TALR_RST;
      calr_r <= rtc_pkg::CALR_RST;
      nv_r <= 4'h0;
    end else begin
      if (wr_ctrl) begin
        upd_time_r <= wdata[rtc_pkg::CTRL_UPD_TIME];
        upd_cal_r <= wdata[rtc_pkg::CTRL_UPD_CAL];
        tev_sel_r <= rtc_pkg::time_event_select_type'(wdata[rtc_pkg::CTRL_TEVSEL_LSB +: 2]);
        cev_sel_r <= rtc_pkg::calendar_event_select_type'(wdata[rtc_pkg::CTRL_CEVSEL_LSB +: 2]);
      end
      if (wr_mode) begin
        hour12_r <= wdata[rtc_pkg::MODE_H12];
      end
      if (wr_talr && talr_ok) begin
        talr_r <= aw & 32'h00FF_FFFF; // see R11
      end
      if (wr_calr && calr_ok) begin
        calr_r <= caw & 32'hBF9F_0000; // see R12
      end
      // Error flag follows the latest write to each register
      if (wr_time) begin
        nv_r[rtc_pkg::NV_TIME] <= ~time_ok; // see R22
      end
      if (wr_cal) begin
        nv_r[rtc_pkg::NV_CAL] <= ~cal_ok; // see R22
      end
      if (wr_talr) begin
        nv_r[rtc_pkg::NV_TALR] <= ~talr_ok;
      end
      if (wr_calr) begin
        nv_r[rtc_pkg::NV_CALR] <= ~calr_ok;
      end
    end
  end

  // ==========================================================
  // Alarm compare and event sources
  wire logic [5:0] alarm_hour = hour12_r ? to24(talr_r.hour, talr_r.half_day_flag)
                                         : talr_r.hour;
  wire logic alarm_any = talr_r.second_alarm_enable | talr_r.minute_alarm_enable
    | talr_r.hour_alarm_enable | calr_r.day_of_month_alarm_enable
    | calr_r.month_alarm_enable;
  wire logic alarm_hit = alarm_any // see R23
    && (!talr_r.second_alarm_enable || talr_r.sec == sec_r) // see R11
    && (!talr_r.minute_alarm_enable || talr_r.min == min_r)
    && (!talr_r.hour_alarm_enable || alarm_hour == hour_r)
    && (!calr_r.day_of_month_alarm_enable || calr_r.date == date_r) // see R12
    && (!calr_r.month_alarm_enable || calr_r.month == month_r);
  // Compare once, right after the counters have moved
  wire logic alarm_set = adv_d_r & alarm_hit; // see R13
  wire logic upd_any = upd_time_r | upd_cal_r;
  wire logic ack_set = tick & upd_any & ~ack_done_r; // see R15
  wire logic time_ev = (tev_sel_r == rtc_pkg::TEV_MINUTE) ? min_step // see R20
    : (tev_sel_r == rtc_pkg::TEV_HOUR) ? hour_step
    : (tev_sel_r == rtc_pkg::TEV_MIDNIGHT) ? midnight_step : noon_step;
  wire logic cal_ev = (cev_sel_r == rtc_pkg::CEV_WEEK) // see R21
    ? day_step && (8'(day_r) == rtc_pkg::DAY_MAX)
    : (cev_sel_r == rtc_pkg::CEV_MONTH) ? month_step
    : (cev_sel_r == rtc_pkg::CEV_YEAR) && year_step;
  logic [4:0] st_set, st_clr;
  assign st_set[rtc_pkg::ST_ACK] = ack_set;
  assign st_set[rtc_pkg::ST_ALARM] = alarm_set;
  assign st_set[rtc_pkg::ST_SEC] = tick; // see R16
  assign st_set[rtc_pkg::ST_TIME_EVENT_FLAG] = time_ev; // see R17
  assign st_set[rtc_pkg::ST_CALENDAR_EVENT_FLAG] = cal_ev; // see R18
  assign st_clr = wr_clr ? wdata[4:0] : 5'h00; // see R19

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_r <= 5'h00;
      ack_done_r <= 1'b0;
      adv_d_r <= 1'b0;
    end else begin
      // A new event outranks a clear landing in the same cycle
      status_r <= (status_r & ~st_clr) | st_set; // see R19
      ack_done_r <= upd_any & (ack_done_r | ack_set);
      adv_d_r <= adv;
    end
  end

  // ==========================================================
  // Read back
  wire logic [6:0] hour12_view = to12(hour_r);
  rtc_pkg::tod_word_type time_view;
  rtc_pkg::cal_word_type cal_view;
  assign time_view = {8'h00, 1'b0, hour12_r & hour12_view[6], // see R4
                      hour12_r ? hour12_view[5:0] : hour_r, 1'b0, min_r, 1'b0, sec_r};
  assign cal_view = {2'b00, date_r, day_r, month_r, year_r, 1'b0, hundreds_of_years_field_r};
  wire logic [31:0] ctrl_view = {14'h0000, 2'(cev_sel_r), 6'h00, 2'(tev_sel_r),
                                 6'h00, upd_cal_r, upd_time_r};
  assign rd_word = (address_i == rtc_pkg::OFS_CTRL) ? ctrl_view
    : (address_i == rtc_pkg::OFS_MODE) ? {31'h0000_0000, hour12_r}
    : (address_i == rtc_pkg::OFS_TIME) ? time_view
    : (address_i == rtc_pkg::OFS_CAL) ? cal_view
    : (address_i == rtc_pkg::OFS_TALR) ? talr_r
    : (address_i == rtc_pkg::OFS_CALR) ? calr_r
    : (address_i == rtc_pkg::OFS_STAT) ? {27'h000_0000, status_r}
    : (address_i == rtc_pkg::OFS_VALID) ? {28'h000_0000, nv_r} : 32'h0000_0000;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      served_r <= 1'b0;
      readdata_o <= 32'h0000_0000;
    end else begin
      served_r <= bus_req & ~served_r;
      if (read_i && !served_r) begin
        readdata_o <= rd_word;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  a_sec_min_range: assert property ( // see R1
    bcd_in(8'(sec_r), rtc_pkg::BCD_ZERO, rtc_pkg::MINSEC_MAX)
    && bcd_in(8'(min_r), rtc_pkg::BCD_ZERO, rtc_pkg::MINSEC_MAX))
    else $error("seconds or minutes out of range");
  a_hundreds_of_years_field_fixed: assert property (8'(hundreds_of_years_field_r) == rtc_pkg::HUNDREDS_OF_YEARS_FIELD_ONLY) // see R5
    else $error("century left 20");
  a_month_date_range: assert property ( // see R7
    bcd_in(8'(month_r), rtc_pkg::BCD_ONE, rtc_pkg::MONTH_MAX)
    && bcd_in(8'(date_r), rtc_pkg::BCD_ONE, rtc_pkg::DATE_MAX))
    else $error("month or date out of range");
  a_weekday_range: assert property ( // see R8
    bcd_in(8'(day_r), rtc_pkg::BCD_ONE, rtc_pkg::DAY_MAX))
    else $error("weekday out of range");
  a_bad_time_kept: assert property ( // see R22
    wr_time && !time_ok && !tick |=> $stable({sec_r, min_r, hour_r}) && nv_r[0])
    else $error("bad time write changed the time or left no error");
  a_sec_flag_sticky: assert property ( // see R16
    tick |=> status_r[rtc_pkg::ST_SEC] ##1 (status_r[rtc_pkg::ST_SEC] || $past(st_clr[2])))
    else $error("second flag lost");
  a_clear_flag: assert property ( // see R19
    st_clr[rtc_pkg::ST_SEC] && !tick |=> !status_r[rtc_pkg::ST_SEC])
    else $error("second flag not cleared");
  a_alarm_gated: assert property ( // see R12
    !alarm_any |=> !$rose(status_r[rtc_pkg::ST_ALARM]))
    else $error("alarm with no field enabled");
  a_alarm_on_match: assert property ( // see R13
    adv && !wr_talr && !wr_calr ##1 alarm_hit |=> status_r[rtc_pkg::ST_ALARM])
    else $error("alarm match did not set the flag");
  a_minute_event: assert property ( // see R20
    tev_sel_r == rtc_pkg::TEV_MINUTE && min_step |=> status_r[rtc_pkg::ST_TIME_EVENT_FLAG])
    else $error("minute event missed");
  a_half_day_read: assert property ( // see R4
    hour12_r && 8'(hour_r) >= rtc_pkg::HOUR12_MAX |-> time_view.half_day_flag)
    else $error("afternoon not shown");

  c_alarm_rise: cover property ($rose(status_r[rtc_pkg::ST_ALARM]));
  c_day_roll: cover property (day_step);
  c_bad_write: cover property (wr_cal && !cal_ok);
  c_ack_seen: cover property (ack_set ##[1:4] wr_clr);

endmodule // rtc_time_calendar_alarm_regs

// ---- verification/rtc_time_calendar_alarm_regs_tb_top.sv ----
/*
  Self-checking bench for the time, calendar and alarm register block.
  Assumes the block's Avalon-MM slave with waitrequest and a short second.
*/
module rtc_time_calendar_alarm_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Stimulus and observation
  // A short second keeps the run brief but leaves room for thirteen accesses
  localparam int unsigned TICK = 40;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] address = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] readdata;
  logic waitrequest;
  logic [31:0] q;
  int mismatches = 0;
  int checked = 0;
  rtc_time_calendar_alarm_regs #(.TICK_CYCLES(TICK)) dut (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .address_i(address), .read_i(rd),
    .write_i(wr), .writedata_i(wdata), .byteenable_i(4'hF),
    .readdata_o(readdata), .waitrequest_o(waitrequest));
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  // ==========================================================
  // Shared tasks
  task automatic finish_test();
    $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Request held until the rising edge where waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    wdata <= d;
    rd <= ~w;
    wr <= w;
    @(posedge mclk_i);
    while (waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        mismatches++;
        finish_test();
      end
      @(posedge mclk_i);
    end
    q = readdata;
    rd <= 1'b0;
    wr <= 1'b0;
    // One idle edge, so the next call never re-raises a strobe in this step
    @(posedge mclk_i);
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(what, q, exp);
  endtask
  // Poll a status bit with a bounded count; exhaustion ends the run as failed
  task automatic poll(input int bit_pos);
    int n;
    n = 0;
    q = 32'h0000_0000;
    while (q[bit_pos] !== 1'b1) begin
      n++;
      if (n > 60) begin
        mismatches++;
        finish_test();
      end
      bus(1'b0, rtc_pkg::OFS_STAT, 32'h0000_0000);
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic test_reset();
    rchk("status", rtc_pkg::OFS_STAT, 32'h0000_0000);
    rchk("time", rtc_pkg::OFS_TIME, rtc_pkg::TIME_RST);
    rchk("calendar", rtc_pkg::OFS_CAL, rtc_pkg::CAL_RST);
    rchk("time alarm", rtc_pkg::OFS_TALR, rtc_pkg::TALR_RST);
    rchk("cal alarm", rtc_pkg::OFS_CALR, rtc_pkg::CALR_RST);
    $display("test_reset done");
  endtask
  task automatic test_update();
    bus(1'b1, rtc_pkg::OFS_CTRL, 32'h0000_0003);
    poll(rtc_pkg::ST_ACK);
    bus(1'b1, rtc_pkg::OFS_CLR, 32'h0000_0001);
    // One in the afternoon in twelve-hour form, then seen in 24 h form
    bus(1'b1, rtc_pkg::OFS_MODE, 32'h0000_0001);
    bus(1'b1, rtc_pkg::OFS_TIME, 32'h0041_0000);
    rchk("pm hour", rtc_pkg::OFS_TIME, 32'h0041_0000);
    bus(1'b1, rtc_pkg::OFS_MODE, 32'h0000_0000);
    rchk("24h hour", rtc_pkg::OFS_TIME, 32'h0013_0000);
    bus(1'b1, rtc_pkg::OFS_TIME, 32'h0023_5958);
    rchk("time set", rtc_pkg::OFS_TIME, 32'h0023_5958);
    bus(1'b1, rtc_pkg::OFS_TIME, 32'h0023_5960);
    rchk("bad second", rtc_pkg::OFS_TIME, 32'h0023_5958);
    rchk("validity", rtc_pkg::OFS_VALID, 32'h0000_0001);
    bus(1'b1, rtc_pkg::OFS_TIME, 32'h0024_0000);
    rchk("bad hour", rtc_pkg::OFS_TIME, 32'h0023_5958);
    bus(1'b1, rtc_pkg::OFS_CAL, 32'h0121_0719);
    rchk("bad century", rtc_pkg::OFS_CAL, rtc_pkg::CAL_RST);
    bus(1'b1, rtc_pkg::OFS_CAL, 32'h31F2_9920);
    rchk("cal set", rtc_pkg::OFS_CAL, 32'h31F2_9920);
    bus(1'b1, rtc_pkg::OFS_CAL, 32'h0113_0720);
    rchk("bad month", rtc_pkg::OFS_CAL, 32'h31F2_9920);
    // Enables already clear: write 00:00:00, then enable hour, minute, second
    bus(1'b1, rtc_pkg::OFS_TALR, 32'h0000_0000);
    bus(1'b1, rtc_pkg::OFS_TALR, 32'h0080_8080);
    rchk("alarm set", rtc_pkg::OFS_TALR, 32'h0080_8080);
    $display("test_update done");
  endtask
  task automatic test_run();
    // Align to a tick while stopped, so the next two writes and the no-alarm check fit inside one second
    bus(1'b1, rtc_pkg::OFS_CLR, 32'h0000_001F);
    poll(rtc_pkg::ST_SEC);
    // Run with midnight as time event and year change as calendar event
    bus(1'b1, rtc_pkg::OFS_CTRL, 32'h0002_0200);
    bus(1'b1, rtc_pkg::OFS_CLR, 32'h0000_001F);
    rchk("no alarm yet", rtc_pkg::OFS_STAT, 32'h0000_0000);
    poll(rtc_pkg::ST_ALARM);
    chk("flags at match", q & 32'h0000_001E, 32'h0000_001E);
    rchk("time at match", rtc_pkg::OFS_TIME, 32'h0000_0000);
    rchk("new year", rtc_pkg::OFS_CAL, 32'h0121_0020);
    bus(1'b1, rtc_pkg::OFS_CLR, 32'h0000_0000);
    rchk("zero clear", rtc_pkg::OFS_STAT, 32'h0000_001E);
    bus(1'b1, rtc_pkg::OFS_CLR, 32'h0000_001F);
    rchk("cleared", rtc_pkg::OFS_STAT, 32'h0000_0000);
    poll(rtc_pkg::ST_SEC);
    // Let two more seconds pass before looking again
    repeat (2 * TICK) @(posedge mclk_i);
    rchk("sticky second", rtc_pkg::OFS_STAT, 32'h0000_0004);
    $display("test_run done");
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    @(posedge mclk_i);
    test_reset();
    test_update();
    test_run();
    finish_test();
  end
endmodule // rtc_time_calendar_alarm_regs_tb_top
